/* verilog/expander_dev.sv */
`timescale 1ns/10ps
module expander_dev (
  input  wire logic       CLOCK,
  input  wire logic       SYS_RST,
  i2c_link_if.dev         LINK,
  input  wire logic       RESET_N,
  input  wire logic       ADDR_SEL,
  input  wire logic [7:0] PORT_IN,
  output logic      [7:0] PORT_OUT,
  output logic      [7:0] PORT_OE,
  output logic            INT_N_OE
);
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_CMD, ST_WDATA, ST_AACK, ST_CACK, ST_DACK, ST_TX, ST_MACK
  } state_t;

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  logic [11:0] sync_s;

  // Bus lines idle high; reset pin held active until settled
  pin_sync #(.WIDTH(12), .INIT(12'hC00)) u_pin_sync (
    .clk  (CLOCK),
    .rst  (SYS_RST),
    .din  ({LINK.scl, LINK.sda, RESET_N, ADDR_SEL, PORT_IN}),
    .dout (sync_s)
  );
  wire       scl_s    = sync_s[11];
  wire       sda_s    = sync_s[10];
  wire       rst_n_s  = sync_s[9];
  wire       strap_s  = sync_s[8];
  wire [7:0] pins_s   = sync_s[7:0];

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  state_t     state_reg;
  state_t     state_next;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic       oe_reg;
  logic       oe_next;
  logic       rd_reg;
  logic       rd_next;
  logic       scl_d_reg;
  logic       sda_d_reg;
  logic [7:0] ptr_reg;
  logic [7:0] pol_reg;
  logic [7:0] snap_reg;
  logic [1:0] init_reg;
  logic [7:0] read_byte;

  // Bus events from the filtered lines
  wire scl_rise  = scl_s & ~scl_d_reg;
  wire scl_fall  = ~scl_s & scl_d_reg;
  wire start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  wire stop_det  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  wire byte_end  = scl_fall & (cnt_reg == expander_pkg::BYTE_BITS);
  // reset pin acts as synchronous clear
  wire soft_rst  = ~rst_n_s;
  wire addr_hit  = shift_reg[7:1] == {expander_pkg::ADDR_HI, strap_s};
  // Pointer and register decode
  wire       ptr_ok  = ptr_reg[7:2] == expander_pkg::CMD_UPPER_OK;
  wire [1:0] code    = ptr_reg[1:0];
  wire       wr_ptr  = (state_reg == ST_CMD) & byte_end;
  wire       wr_data = (state_reg == ST_WDATA) & byte_end & ptr_ok;
  wire [7:0] in_level = pins_s ^ pol_reg;

  // ------------------------------------------------------------
  // Read data selection
  // ------------------------------------------------------------
  // low bits pick register; others read fixed
  // pins whatever direction; latch, not pin
  assign read_byte = !ptr_ok                              ? expander_pkg::RSV_READ
                   : (code == expander_pkg::CMD_INPUT)    ? in_level
                   : (code == expander_pkg::CMD_OUTPUT)   ? PORT_OUT
                   : (code == expander_pkg::CMD_POLARITY) ? pol_reg
                   : ~PORT_OE;

  // ------------------------------------------------------------
  // Protocol state machine
  // ------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    shift_next = shift_reg;
    oe_next    = oe_reg;
    rd_next    = rd_reg;
    if (soft_rst) begin
      state_next = ST_IDLE;
      cnt_next   = 4'h0;
      oe_next    = 1'b0;
      rd_next    = 1'b0;
    end else if (stop_det) begin
      state_next = ST_IDLE;
      oe_next    = 1'b0;
    end else if (start_det) begin
      state_next = ST_ADDR;
      cnt_next   = 4'h0;
      oe_next    = 1'b0;
    end else begin
      unique case (state_reg)
        ST_ADDR, ST_CMD, ST_WDATA: begin
          if (scl_rise) begin
            shift_next = {shift_reg[6:0], sda_s};
            cnt_next   = cnt_reg + 4'h1;
          end else if (byte_end) begin
            cnt_next = 4'h0;
            oe_next  = 1'b1;
            if (state_reg == ST_ADDR) begin
              rd_next    = shift_reg[0] == expander_pkg::RW_READ;
              state_next = addr_hit ? ST_AACK : ST_IDLE;
              oe_next    = addr_hit;
            end else if (state_reg == ST_CMD) begin
              state_next = ST_CACK;
            end else begin
              state_next = ST_DACK;
            end
          end
        end
        ST_AACK: begin
          if (scl_fall) begin
            // read starts after acknowledged read address
            if (rd_reg) begin
              state_next = ST_TX;
              shift_next = read_byte;
              oe_next    = ~read_byte[7];
            end else begin
              state_next = ST_CMD;
              oe_next    = 1'b0;
            end
          end
        end
        ST_CACK, ST_DACK: begin
          if (scl_fall) begin
            state_next = ST_WDATA;
            oe_next    = 1'b0;
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (cnt_reg[2:0] == expander_pkg::LAST_BIT) begin
              state_next = ST_MACK;
              cnt_next   = 4'h0;
              oe_next    = 1'b0;
            end else begin
              shift_next = {shift_reg[6:0], 1'b0};
              oe_next    = ~shift_reg[6];
              cnt_next   = cnt_reg + 4'h1;
            end
          end
        end
        ST_MACK: begin
          // NACK releases the line until stop
          if (scl_rise && sda_s) begin
            state_next = ST_IDLE;
          end else if (scl_fall) begin
            state_next = ST_TX;
            shift_next = read_byte;
            oe_next    = ~read_byte[7];
          end
        end
        default: state_next = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= 4'h0;
      shift_reg <= 8'h00;
      oe_reg    <= 1'b0;
      rd_reg    <= 1'b0;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      shift_reg <= shift_next;
      oe_reg    <= oe_next;
      rd_reg    <= rd_next;
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end
  assign LINK.sda_dev_oe = oe_reg;

  // ------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------
  // command byte stored; held until rewritten
  wire [7:0] ptr_next = soft_rst ? expander_pkg::PTR_RST : wr_ptr ? shift_reg : ptr_reg;
  // data committed at its acknowledge phase
  wire wr_out = wr_data & (code == expander_pkg::CMD_OUTPUT);
  wire wr_pol = wr_data & (code == expander_pkg::CMD_POLARITY);
  wire wr_dir = wr_data & (code == expander_pkg::CMD_DIRECTION);
  wire [7:0] out_next   = soft_rst ? expander_pkg::OUT_RST : wr_out ? shift_reg : PORT_OUT;
  wire [7:0] pol_next   = soft_rst ? expander_pkg::POL_RST : wr_pol ? shift_reg : pol_reg;
  wire [7:0] drive_next = soft_rst ? expander_pkg::DRIVE_RST : wr_dir ? ~shift_reg : PORT_OE;
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ptr_reg  <= expander_pkg::PTR_RST;
      PORT_OUT <= expander_pkg::OUT_RST;
      pol_reg  <= expander_pkg::POL_RST;
      PORT_OE  <= expander_pkg::DRIVE_RST;
    end else begin
      ptr_reg  <= ptr_next;
      PORT_OUT <= out_next;
      pol_reg  <= pol_next;
      PORT_OE  <= drive_next;
    end
  end

  // ------------------------------------------------------------
  // Change-detect interrupt
  // ------------------------------------------------------------
  // input read clears at the acknowledge bit rise
  wire read_clr = (state_reg == ST_MACK) & scl_rise & ptr_ok
                  & (code == expander_pkg::CMD_INPUT);
  wire settling = init_reg != 2'h0;
  wire [7:0] snap_next = (soft_rst | settling | read_clr) ? pins_s : snap_reg;
  wire [1:0] init_next = soft_rst ? expander_pkg::INIT_CYC
                       : settling ? init_reg - 2'h1 : init_reg;
  // input differs from snapshot; outputs masked
  wire int_next = ~settling & ~soft_rst & (|((pins_s ^ snap_reg) & ~PORT_OE));
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      snap_reg <= 8'h00;
      init_reg <= expander_pkg::INIT_CYC;
      INT_N_OE <= 1'b0;
    end else begin
      snap_reg <= snap_next;
      init_reg <= init_next;
      INT_N_OE <= int_next;
    end
  end
endmodule

/* verilog/expander_pkg.sv */
package expander_pkg;
  // ------------------------------------------------------------
  // Slave address and direction bit
  // ------------------------------------------------------------
  localparam logic [5:0] ADDR_HI  = 6'h10;
  localparam logic       RW_READ  = 1'h1;
  localparam logic       RW_WRITE = 1'h0;
  // ------------------------------------------------------------
  // Command codes and reset values
  // ------------------------------------------------------------
  localparam logic [1:0] CMD_INPUT     = 2'h0;
  localparam logic [1:0] CMD_OUTPUT    = 2'h1;
  localparam logic [1:0] CMD_POLARITY  = 2'h2;
  localparam logic [1:0] CMD_DIRECTION = 2'h3;
  localparam logic [5:0] CMD_UPPER_OK  = 6'h00;
  localparam logic [7:0] OUT_RST       = 8'hFF;
  localparam logic [7:0] POL_RST       = 8'h00;
  localparam logic [7:0] DRIVE_RST     = 8'h00;
  localparam logic [7:0] PTR_RST       = 8'h00;
  localparam logic [7:0] RSV_READ      = 8'h00;
  // ------------------------------------------------------------
  // Bit counting and start-up settling
  // ------------------------------------------------------------
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [2:0] LAST_BIT  = 3'h7;
  localparam logic [1:0] INIT_CYC  = 2'h3;
  // ------------------------------------------------------------
  // Controller timing and register map
  // ------------------------------------------------------------
  localparam int         CLK_PERIOD_NS = 10;
  localparam int         SCL_PERIOD_NS = 2500;
  localparam logic [7:0] QUARTER_CYC   = 8'((SCL_PERIOD_NS / 4) / CLK_PERIOD_NS);
  localparam logic [2:0] H_TARGET = 3'h0;
  localparam logic [2:0] H_PTR    = 3'h1;
  localparam logic [2:0] H_WDATA  = 3'h2;
  localparam logic [2:0] H_CTRL   = 3'h3;
  localparam logic [2:0] H_RDATA  = 3'h4;
  localparam int         CTRL_GO    = 0;
  localparam int         CTRL_READ  = 1;
  localparam int         CTRL_NOPTR = 2;
  localparam logic [6:0] TARGET_RST = 7'h20;
  localparam logic [2:0] STOP_STEP  = 3'h7;
endpackage

/* verilog/i2c_link_if.sv */
`timescale 1ns/10ps
interface i2c_link_if;
  logic scl_host_oe;
  logic sda_host_oe;
  logic sda_dev_oe;
  logic scl;
  logic sda;

  // Open-drain wired-AND with pull-ups
  assign scl = ~scl_host_oe;
  assign sda = ~(sda_host_oe | sda_dev_oe);

  modport dev  (input scl, input sda, output sda_dev_oe);
  modport host (input scl, input sda, output scl_host_oe, output sda_host_oe);
endinterface

/* verilog/pin_sync.sv */
`timescale 1ns/10ps
module pin_sync #(
  parameter int               WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT  = '0
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  wire  [WIDTH-1:0] agree = ~(s2_reg ^ s3_reg);

  // Three stages; accept a bit once stages two and three agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_reg <= INIT;
      s2_reg <= INIT;
      s3_reg <= INIT;
      dout   <= INIT;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      dout   <= (s2_reg & agree) | (dout & ~agree);
    end
  end
endmodule

/* verilog/expander_host.sv */
`timescale 1ns/10ps
module expander_host (
  input  wire logic       CLOCK,
  input  wire logic       SYS_RST,
  i2c_link_if.host        LINK,
  input  wire logic [2:0] ADDR,
  input  wire logic [7:0] WR_DATA,
  input  wire logic       WR_EN,
  input  wire logic       RD_EN,
  output logic      [7:0] RD_DATA
);
  typedef enum logic [1:0] {H_IDLE, H_WAIT, H_RUN} hstate_t;
  typedef enum logic [1:0] {IT_START, IT_TX, IT_RX, IT_STOP} item_t;

  hstate_t    st_reg;
  item_t      item;
  logic [7:0] ibyte;
  logic [1:0] bus_s;
  logic [6:0] target_reg;
  logic [7:0] hptr_reg;
  logic [7:0] wdat_reg;
  logic [7:0] rdat_reg;
  logic       mread_reg;
  logic       noptr_reg;
  logic       nack_reg;
  logic [2:0] step_reg;
  logic [7:0] q_reg;
  logic [1:0] ph_reg;
  logic [3:0] bit_reg;
  logic       scl_oe_reg;
  logic       sda_oe_reg;
  logic [7:0] rd_mux;

  pin_sync #(.WIDTH(2), .INIT(2'h3)) u_bus_sync (
    .clk  (CLOCK),
    .rst  (SYS_RST),
    .din  ({LINK.scl, LINK.sda}),
    .dout (bus_s)
  );

  // ------------------------------------------------------------
  // Transfer sequence decode
  // ------------------------------------------------------------
  // LSB chooses write or read
  wire [7:0] addr_w = {target_reg, expander_pkg::RW_WRITE};
  wire [7:0] addr_r = {target_reg, expander_pkg::RW_READ};

  // write sequence; pointer, repeated start, read
  always_comb begin
    item  = IT_STOP;
    ibyte = 8'hFF;
    if (!mread_reg) begin
      unique case (step_reg)
        3'h0:    item = IT_START;
        3'h1:    begin item = IT_TX; ibyte = addr_w; end
        3'h2:    begin item = IT_TX; ibyte = hptr_reg; end
        3'h3:    begin item = IT_TX; ibyte = wdat_reg; end
        default: item = IT_STOP;
      endcase
    end else if (noptr_reg) begin
      unique case (step_reg)
        3'h0:    item = IT_START;
        3'h1:    begin item = IT_TX; ibyte = addr_r; end
        3'h2:    item = IT_RX;
        default: item = IT_STOP;
      endcase
    end else begin
      unique case (step_reg)
        3'h0, 3'h3: item = IT_START;
        3'h1:    begin item = IT_TX; ibyte = addr_w; end
        3'h2:    begin item = IT_TX; ibyte = hptr_reg; end
        3'h4:    begin item = IT_TX; ibyte = addr_r; end
        3'h5:    item = IT_RX;
        default: item = IT_STOP;
      endcase
    end
  end

  // ninth bit of a read left high as NACK
  wire last_bit = bit_reg == expander_pkg::BYTE_BITS;
  wire drive_hi = (item == IT_RX) | last_bit
                | ibyte[expander_pkg::LAST_BIT - bit_reg[2:0]];
  wire tick     = q_reg == 8'h00;
  // bus idle means both lines high
  wire bus_idle = bus_s[1] & bus_s[0];
  wire go       = WR_EN & (ADDR == expander_pkg::H_CTRL) & WR_DATA[expander_pkg::CTRL_GO]
                & (st_reg == H_IDLE);

  // Register read selection
  assign rd_mux = (ADDR == expander_pkg::H_TARGET) ? {1'b0, target_reg}
                : (ADDR == expander_pkg::H_PTR)    ? hptr_reg
                : (ADDR == expander_pkg::H_WDATA)  ? wdat_reg
                : (ADDR == expander_pkg::H_CTRL)   ? {6'h00, nack_reg, st_reg != H_IDLE}
                : (ADDR == expander_pkg::H_RDATA)  ? rdat_reg : 8'h00;

  // ------------------------------------------------------------
  // Register port
  // ------------------------------------------------------------
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      target_reg <= expander_pkg::TARGET_RST;
      hptr_reg   <= 8'h00;
      wdat_reg   <= 8'h00;
      RD_DATA    <= 8'h00;
    end else begin
      RD_DATA <= RD_EN ? rd_mux : 8'h00;
      if (WR_EN && st_reg == H_IDLE) begin
        if (ADDR == expander_pkg::H_TARGET) target_reg <= WR_DATA[6:0];
        if (ADDR == expander_pkg::H_PTR) hptr_reg <= WR_DATA;
        if (ADDR == expander_pkg::H_WDATA) wdat_reg <= WR_DATA;
      end
    end
  end

  // ------------------------------------------------------------
  // Bit sequencer, four phases per SCL period
  // ------------------------------------------------------------
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      st_reg <= H_IDLE;
      mread_reg <= 1'b0;
      noptr_reg <= 1'b0;
      nack_reg <= 1'b0;
      rdat_reg <= 8'h00;
      step_reg <= 3'h0;
      q_reg <= 8'h00;
      ph_reg <= 2'h0;
      bit_reg <= 4'h0;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else begin
      q_reg <= tick ? expander_pkg::QUARTER_CYC - 8'h01 : q_reg - 8'h01;
      if (go) begin
        st_reg    <= H_WAIT;
        mread_reg <= WR_DATA[expander_pkg::CTRL_READ];
        noptr_reg <= WR_DATA[expander_pkg::CTRL_NOPTR];
        nack_reg  <= 1'b0;
        step_reg  <= 3'h0;
        ph_reg    <= 2'h0;
        bit_reg   <= 4'h0;
      end else if (st_reg == H_WAIT) begin
        // start only after lines seen high
        if (!bus_idle) q_reg <= expander_pkg::QUARTER_CYC - 8'h01;
        else if (tick) st_reg <= H_RUN;
      end else if (st_reg == H_RUN && tick) begin
        ph_reg <= ph_reg + 2'h1;
        unique case (item)
          IT_START: begin
            if (ph_reg == 2'h0) sda_oe_reg <= 1'b0;
            if (ph_reg == 2'h1) scl_oe_reg <= 1'b0;
            if (ph_reg == 2'h2) sda_oe_reg <= 1'b1;
            if (ph_reg == 2'h3) begin
              scl_oe_reg <= 1'b1;
              step_reg   <= step_reg + 3'h1;
            end
          end
          IT_TX, IT_RX: begin
            if (ph_reg == 2'h0) sda_oe_reg <= ~drive_hi;
            if (ph_reg == 2'h1) scl_oe_reg <= 1'b0;
            if (ph_reg == 2'h2) begin
              if (item == IT_RX && !last_bit) rdat_reg <= {rdat_reg[6:0], bus_s[0]};
              if (item == IT_TX && last_bit && bus_s[0]) nack_reg <= 1'b1;
            end
            if (ph_reg == 2'h3) begin
              scl_oe_reg <= 1'b1;
              bit_reg    <= last_bit ? 4'h0 : bit_reg + 4'h1;
              if (last_bit) begin
                step_reg <= (item == IT_TX && nack_reg) ? expander_pkg::STOP_STEP
                          : step_reg + 3'h1;
              end
            end
          end
          IT_STOP: begin
            if (ph_reg == 2'h0) sda_oe_reg <= 1'b1;
            if (ph_reg == 2'h1) scl_oe_reg <= 1'b0;
            if (ph_reg == 2'h2) sda_oe_reg <= 1'b0;
            if (ph_reg == 2'h3) st_reg <= H_IDLE;
          end
        endcase
      end
    end
  end

  assign LINK.scl_host_oe = scl_oe_reg;
  assign LINK.sda_host_oe = sda_oe_reg;
endmodule

/* tb/expander_link_chk.sv */
`timescale 1ns/10ps
module expander_link_chk (
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic scl_host_oe,
  input wire logic sda_host_oe,
  input wire logic sda_dev_oe,
  input wire logic scl,
  input wire logic sda
);
  logic       scl_q, sda_q, in_addr, wmode, rmode;
  logic [3:0] bitc;
  logic [8:0] sh;
  // Bus phase decode
  wire        hi    = scl & scl_q;
  wire        rise  = scl & ~scl_q;
  wire        start = hi & sda_q & ~sda;
  wire        ackb  = hi & (bitc == 4'h9);

  // Bit count, shifted byte and transfer direction
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      {scl_q, sda_q, in_addr, wmode, rmode} <= 5'h18;
      bitc <= 4'h0;
      sh <= 9'h000;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (start) begin
        {in_addr, wmode, rmode, bitc} <= 7'h40;
      end else if (rise) begin
        bitc <= (bitc == 4'h9) ? 4'h1 : bitc + 4'h1;
        sh <= {sh[7:0], sda};
        in_addr <= in_addr & (bitc != 4'h9);
      end else if (ackb && in_addr) begin
        wmode <= ~sh[1] & ~sda;
        rmode <= sh[1] & ~sda;
      end
    end
  end

  // ------------------------------------------------
  // Link properties
  // ------------------------------------------------
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  sequence s_start; scl && $fell(sda); endsequence
  sequence s_stop; scl && $rose(sda); endsequence
  property p_scl_high; $rose(scl) |-> scl [*8]; endproperty
  property p_scl_low; $fell(scl) |-> !scl [*8]; endproperty
  property p_dev_steady; hi |-> $stable(sda_dev_oe); endproperty
  property p_start_idle; s_start |-> $past(scl, 8) && !$past(sda_dev_oe); endproperty
  property p_stop_free; s_stop |-> !sda_dev_oe [*8]; endproperty
  property p_addr_quiet; in_addr && hi && bitc != 4'h9 |-> !sda_dev_oe; endproperty
  property p_foreign;
    ackb && in_addr && sh[8:3] != expander_pkg::ADDR_HI |-> !sda_dev_oe;
  endproperty
  property p_wr_ack; ackb && !in_addr && wmode |-> sda_dev_oe; endproperty
  property p_rd_free; ackb && !in_addr && rmode |-> !sda_dev_oe; endproperty
  property p_one_talker; hi && sda_dev_oe |-> !sda_host_oe; endproperty
  a_scl_high: assert property (p_scl_high)
    else $error("clock high phase short");
  a_scl_low: assert property (p_scl_low)
    else $error("clock low phase short");
  a_dev_steady: assert property (p_dev_steady)
    else $error("device data moved with clock high");
  a_start_idle: assert property (p_start_idle)
    else $error("start on busy bus");
  a_stop_free: assert property (p_stop_free)
    else $error("device drives after stop");
  a_addr_quiet: assert property (p_addr_quiet)
    else $error("device drives during address");
  a_foreign: assert property (p_foreign)
    else $error("foreign address acknowledged");
  a_wr_ack: assert property (p_wr_ack)
    else $error("written byte not acknowledged");
  a_rd_free: assert property (p_rd_free)
    else $error("device holds master ack bit");
  a_one_talker: assert property (p_one_talker)
    else $error("both ends drive data with clock high");
endmodule

/* tb/i2c_eight_bit_port_expander_bench.sv */
`timescale 1ns/10ps
module i2c_eight_bit_port_expander_bench;
  logic       clk, rst, rst_n, addr_sel, wr_en, rd_en, int_oe;
  logic [2:0] addr;
  logic [7:0] port_in, wr_data, rd_data, port_out, port_oe, v, st, d, o, p;
  int         num_errors, check_count;

  i2c_link_if i2c_link_if_i ();
  expander_dev expander_dev_i (
    .CLOCK(clk), .SYS_RST(rst), .LINK(i2c_link_if_i.dev), .RESET_N(rst_n),
    .ADDR_SEL(addr_sel), .PORT_IN(port_in), .PORT_OUT(port_out),
    .PORT_OE(port_oe), .INT_N_OE(int_oe));
  expander_host expander_host_i (
    .CLOCK(clk), .SYS_RST(rst), .LINK(i2c_link_if_i.host), .ADDR(addr),
    .WR_DATA(wr_data), .WR_EN(wr_en), .RD_EN(rd_en), .RD_DATA(rd_data));
  expander_link_chk expander_link_chk_i (
    .CLOCK(clk), .SYS_RST(rst), .scl_host_oe(i2c_link_if_i.scl_host_oe),
    .sda_host_oe(i2c_link_if_i.sda_host_oe), .sda_dev_oe(i2c_link_if_i.sda_dev_oe),
    .scl(i2c_link_if_i.scl), .sda(i2c_link_if_i.sda));

  // System clock
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  // Expected view of the input register
  function automatic logic [7:0] f_in(input logic [7:0] pin, pol);
    return pin ^ pol;
  endfunction

  task automatic chk(input logic [7:0] g, e);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask

  // Register port cycles
  task automatic wr(input logic [2:0] a, input logic [7:0] x);
    @(posedge clk);
    addr <= a;
    wr_data <= x;
    wr_en <= 1'h1;
    @(posedge clk);
    wr_en <= 1'h0;
  endtask

  task automatic rd(input logic [2:0] a);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'h1;
    @(posedge clk);
    rd_en <= 1'h0;
    @(posedge clk);
    v = rd_data;
  endtask

  // Start a transfer and poll until idle
  task automatic go(input logic [7:0] c);
    wr(3'h3, c);
    st = 8'h01;
    for (int i = 0; i < 8000 && st[0] !== 1'h0; i++) begin
      rd(3'h3);
      st = v;
    end
    if (st[0] !== 1'h0) begin
      num_errors++;
      $display("[ERR] %0t transfer never finished", $time);
    end
  endtask

  task automatic put(input logic [7:0] r, x);
    wr(3'h1, r);
    wr(3'h2, x);
    go(8'h01);
  endtask

  task automatic get(input logic [7:0] r, input logic nop);
    wr(3'h1, r);
    go({5'h00, nop, 2'h3});
    rd(3'h4);
  endtask

  task automatic pins(input logic [7:0] x);
    port_in <= x;
    repeat (10) @(posedge clk);
  endtask

  task automatic final_report;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (95000) @(posedge clk);
    num_errors++;
    final_report;
  end

  // ------------------------------------------------
  // Test sequence
  // ------------------------------------------------
  initial begin
    {rst, rst_n, addr_sel, wr_en, rd_en} = 5'h18;
    addr = 3'h0;
    wr_data = 8'h00;
    port_in = 8'h5A;
    num_errors = 0;
    check_count = 0;
    v = 8'($urandom(32'hC2F0));
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    repeat (10) @(posedge clk);
    chk(port_out, 8'hFF);
    chk(port_oe, 8'h00);
    pins(8'h5B);
    chk({7'h00, int_oe}, 8'h01);
    pins(8'h5A);
    chk({7'h00, int_oe}, 8'h00);
    pins(8'h5B);
    get(8'h00, 1'h0);
    chk(v, 8'h5B);
    chk({7'h00, int_oe}, 8'h00);
    $display("test reset and interrupt done");
    d = 8'($urandom) & 8'h7F;
    o = 8'($urandom);
    put(8'h03, d);
    chk(port_oe, ~d);
    put(8'h01, o);
    chk(port_out, o);
    pins(port_in ^ 8'h80);
    chk({7'h00, int_oe}, 8'h00);
    get(8'h00, 1'h1);
    chk(v, o);
    p = 8'($urandom) & d;
    put(8'h02, p);
    pins(8'($urandom));
    get(8'h00, 1'h0);
    chk(v, f_in(port_in, p));
    $display("test port registers done");
    put(8'h04, 8'($urandom));
    chk(port_out, o);
    get(8'h00, 1'h1);
    chk(v, 8'h00);
    wr(3'h0, 8'h22);
    put(8'h01, 8'h00);
    chk({7'h00, st[1]}, 8'h01);
    chk(port_out, o);
    addr_sel <= 1'h1;
    wr(3'h0, 8'h21);
    put(8'h01, ~o);
    chk({7'h00, st[1]}, 8'h00);
    chk(port_out, ~o);
    $display("test address done");
    rst_n <= 1'h0;
    repeat (10) @(posedge clk);
    rst_n <= 1'h1;
    repeat (10) @(posedge clk);
    chk(port_out, 8'hFF);
    chk(port_oe, 8'h00);
    get(8'h02, 1'h0);
    chk(v, 8'h00);
    $display("test reset pin done");
    final_report;
  end
endmodule
